// ---- src/rrx_exec.sv ----
`timescale 1ns/1ns

// How it works
// - software reset requests device reset and clears the reset-instruction flag
// - interrupt return pops stack into pc and sets global interrupt enable
// - literal return loads literal into accumulator, pc from stack top, two cycles
// - subroutine return pops stack into pc in two cycles, flags untouched
// - left rotate shifts up, bit 7 to carry, old carry to bit 0
// - destination bit 0 writes accumulator, 1 writes the file register back
module rrx_exec
  import rrx_pkg::*;
(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // instruction stream
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr,
  input  wire logic [DATA_W-1:0]       file_rdata,
  output logic                         instr_ready,
  output logic                         flush,
  // call side of the return stack
  input  wire logic                    push_valid,
  input  wire logic [PC_W-1:0]         push_addr,
  // core state
  output logic      [PC_W-1:0]         pc,
  output logic      [DATA_W-1:0]       w_reg,
  output logic                         carry,
  output logic                         global_irq_enable,
  output logic                         reset_instr_flag,
  output logic                         device_reset_req,
  output rrx_fwr_t                     file_wr
);

  // ==========================================================
  // helpers
  // rotate through carry, result {carry_out, data}
  function automatic logic [DATA_W:0] rotl(input logic [DATA_W-1:0] d, input logic c);
    rotl = {d, c};
  endfunction

  // index of the stack top for a given pointer
  function automatic logic [IDX_W-1:0] top_idx(input logic [SP_W-1:0] p);
    top_idx = p[IDX_W-1:0] - 4'h1;
  endfunction

  // ==========================================================
  // state
  logic [PC_W-1:0]   stack_mem [STK_DEPTH];
  logic [SP_W-1:0]   sp;
  rrx_state_t        state;
  logic              core_en;
  rrx_instr_t        iw;
  logic              take;
  logic              is_reset;
  logic              is_irq_ret;
  logic              is_return;
  logic              is_lit_ret;
  logic              is_rot;
  logic              do_pop;
  logic              do_push;
  logic [PC_W-1:0]   stack_top;
  logic [DATA_W:0]   rot;
  logic              apb_setup;
  logic              apb_wr;
  logic              addr_hit;
  logic [31:0]       rd_mux;

  // ==========================================================
  // decode
  assign iw        = instr;
  assign take      = instr_valid & instr_ready & core_en;
  assign is_reset  = take & (instr == OP_RESET);
  assign is_irq_ret = take & (instr == OP_IRQ_RET);
  assign is_return  = take & ({instr[15:1], 1'b0} == OP_RETURN);
  assign is_lit_ret = take & (instr[15:8] == OP_LIT_RET_HI);
  assign is_rot     = take & (iw.major == OP_ROT_LEFT_HI);
  assign do_pop     = is_irq_ret | is_return | is_lit_ret;
  // a pop in the same cycle wins; the call must retry
  assign do_push   = push_valid & ~do_pop & ~is_reset & (sp != SP_W'(STK_DEPTH));
  assign stack_top = stack_mem[top_idx(sp)];
  assign rot       = rotl(file_rdata, carry);

  // ==========================================================
  // apb decode
  assign apb_setup = psel & penable & ~pready;
  assign apb_wr    = psel & penable & pready & pwrite & addr_hit;

  // read mux, reserved bits read as zero
  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: rd_mux[CTRL_EN_BIT] = core_en;
      ADDR_PWR:  rd_mux[PWR_FLAG_BIT] = reset_instr_flag;
      ADDR_IRQ:  rd_mux[IRQ_EN_BIT] = global_irq_enable;
      ADDR_STAT:
      begin
        rd_mux[PC_W-1:0]                   = pc;
        rd_mux[STAT_SP_LSB +: SP_W]        = sp;
        rd_mux[STAT_BSY_BIT]               = (state == RRX_FLUSH);
      end
      ADDR_WREG:
      begin
        rd_mux[DATA_W-1:0] = w_reg;
        rd_mux[WREG_C_BIT] = carry;
      end
      default:   addr_hit = 1'b0;
    endcase
  end

  // one wait state; data is captured at the same edge pready rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      if (apb_setup & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_en <= CTRL_EN_RST;
    else if (is_reset)
      core_en <= CTRL_EN_RST;
    else if (apb_wr && paddr == ADDR_CTRL)
      core_en <= pwdata[CTRL_EN_BIT];
  end

  // reset-instruction flag: software sets it, the reset op clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_instr_flag <= FLAG_RST;
    else if (is_reset)
      reset_instr_flag <= 1'b0; // hardware event beats a same-cycle write
    else if (apb_wr && paddr == ADDR_PWR)
      reset_instr_flag <= pwdata[PWR_FLAG_BIT];
  end

  // one-cycle request to the reset controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      device_reset_req <= 1'b0;
    else
      device_reset_req <= is_reset;
  end

  // global interrupt enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_irq_enable <= IRQ_EN_RST;
    else if (is_reset)
      global_irq_enable <= IRQ_EN_RST;
    else if (is_irq_ret)
      global_irq_enable <= 1'b1; // set beats a same-cycle software clear
    else if (apb_wr && paddr == ADDR_IRQ)
      global_irq_enable <= pwdata[IRQ_EN_BIT];
  end

  // ==========================================================
  // return stack; memory needs no reset, only the pointer does
  always_ff @(posedge pclk)
  begin
    if (do_push)
      stack_mem[sp[IDX_W-1:0]] <= push_addr;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sp <= '0;
    else if (is_reset)
      sp <= '0;
    else if (do_pop && sp != '0)
      sp <= sp - 5'h01; // underflow holds at zero
    else if (do_push)
      sp <= sp + 5'h01;
  end

  // ==========================================================
  // program counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc <= PC_RST;
    else if (is_reset)
      pc <= PC_RST;
    else if (do_pop)
      pc <= stack_top;
    else if (take)
      pc <= pc + 15'h0001;
  end

  // ==========================================================
  // accumulator and carry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      w_reg <= W_RST;
    else if (is_reset)
      w_reg <= W_RST;
    else if (is_lit_ret)
      w_reg <= instr[DATA_W-1:0];
    else if (is_rot && !iw.dest)
      w_reg <= rot[DATA_W-1:0];
  end

  // returns leave carry alone; only the rotate and the reset op touch it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      carry <= 1'b0;
    else if (is_reset)
      carry <= 1'b0;
    else if (is_rot)
      carry <= rot[DATA_W];
  end

  // file register write-back, one-cycle strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      file_wr <= '0;
    else
    begin
      file_wr.we   <= is_rot & iw.dest;
      file_wr.addr <= iw.file;
      file_wr.data <= rot[DATA_W-1:0];
    end
  end

  // ==========================================================
  // two-cycle sequencing: second cycle drops the fetched word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= RRX_EXEC;
    else if (is_reset)
      state <= RRX_EXEC;
    else
    begin
      unique case (state)
        RRX_EXEC:  state <= do_pop ? RRX_FLUSH : RRX_EXEC;
        RRX_FLUSH: state <= RRX_EXEC;
      endcase
    end
  end

  // ready and flush are registered so the top outputs stay clean
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_ready <= 1'b1;
      flush       <= 1'b0;
    end
    else
    begin
      instr_ready <= ~do_pop;
      flush       <= do_pop;
    end
  end

endmodule

// ---- src/rrx_pkg.sv ----
package rrx_pkg;

  // ==========================================================
  // widths and sizes
  localparam int DATA_W    = 8;
  localparam int PC_W      = 15;
  localparam int STK_DEPTH = 16;
  localparam int SP_W      = 5;
  localparam int IDX_W     = 4;
  localparam int ADDR_W    = 12;

  // ==========================================================
  // instruction encodings (16-bit words)
  localparam logic [15:0] OP_RESET    = 16'h00FF;
  localparam logic [15:0] OP_IRQ_RET     = 16'h0010;
  localparam logic [15:0] OP_RETURN      = 16'h0012; // bit 0 is the s bit
  localparam logic [7:0]  OP_LIT_RET_HI  = 8'h0C;
  localparam logic [5:0]  OP_ROT_LEFT_HI = 6'h0D;    // 0011 01da ffff ffff

  // ==========================================================
  // register offsets, field positions and reset values
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_PWR  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_IRQ  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_WREG = 12'h010;
  localparam int CTRL_EN_BIT  = 0;
  localparam int PWR_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT   = 7;
  localparam int STAT_SP_LSB  = 16;
  localparam int STAT_BSY_BIT = 24;
  localparam int WREG_C_BIT   = 8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic FLAG_RST    = 1'b1;
  localparam logic IRQ_EN_RST  = 1'b0;
  localparam logic [PC_W-1:0]   PC_RST = 15'h0000;
  localparam logic [DATA_W-1:0] W_RST  = 8'h00;

  // ==========================================================
  // types
  typedef enum logic {
    RRX_EXEC  = 1'b0,
    RRX_FLUSH = 1'b1
  } rrx_state_t;

  typedef struct packed {
    logic [5:0]        major;
    logic              dest;
    logic              bank;
    logic [DATA_W-1:0] file;
  } rrx_instr_t;

  typedef struct packed {
    logic              we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rrx_fwr_t;

endpackage

// ---- sim/rrx_exec_monitor.sv ----
`timescale 1ns/1ns
module rrx_exec_monitor
  import rrx_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // instruction side
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0]  file_rdata,
  input wire logic        instr_ready,
  input wire logic        flush,
  // core state
  input wire logic [14:0] pc,
  input wire logic [7:0]  w_reg,
  input wire logic        carry,
  input wire logic        global_irq_enable,
  input wire logic        reset_instr_flag,
  input wire logic        device_reset_req,
  input wire rrx_fwr_t    file_wr
);
  // ==========
  // helpers
  logic       en;
  logic       take;
  logic       fmsb;
  logic [7:0] lit;
  logic [7:0] rot_res;
  rrx_instr_t ins;
  assign ins = instr;
  assign lit = instr[7:0];
  assign fmsb = file_rdata[7];
  assign rot_res = {file_rdata[6:0], carry};
  assign take = instr_valid && instr_ready && en;
  // enable mirror, so a disabled core is not judged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en <= 1'b1;
    else if (take && instr == OP_RESET)
      en <= 1'b1;
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      en <= pwdata[CTRL_EN_BIT];
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ret;
    take && (instr[15:1] == OP_RETURN[15:1] || instr == OP_IRQ_RET || instr[15:8] == OP_LIT_RET_HI);
  endsequence
  sequence s_rot;
    take && ins.major == 6'h0d;
  endsequence
  sequence s_flush2;
    flush && !instr_ready ##1 instr_ready && !flush;
  endsequence
  a_reset_op_req: assert property (take && instr == OP_RESET |=> device_reset_req && !reset_instr_flag)
    else $error("reset op without request or flag clear");
  a_irq_ret_enable: assert property (take && instr == OP_IRQ_RET |=> global_irq_enable)
    else $error("irq return left enable low");
  a_lit_ret_w: assert property (take && instr[15:8] == 8'h0c |=> w_reg == $past(lit) && $stable(carry))
    else $error("literal return bad accumulator");
  a_sub_ret_flags: assert property (take && instr[15:1] == OP_RETURN[15:1] |=> $stable(carry))
    else $error("subroutine return touched carry");
  a_rot_carry_pc: assert property (s_rot |=> carry == $past(fmsb) && pc == $past(pc) + 15'h0001)
    else $error("rotate carry or pc wrong");
  a_rot_file_dest: assert property (s_rot ##0 ins.dest |=> file_wr.we && file_wr.data == $past(rot_res)
    && file_wr.addr == $past(lit)) else $error("rotate file write wrong");
  a_rot_w_dest: assert property (s_rot ##0 !ins.dest |=> w_reg == $past(rot_res) && !file_wr.we)
    else $error("rotate accumulator write wrong");
  a_ret_two_cycle: assert property (s_ret |=> s_flush2)
    else $error("return not two cycles with flush");
endmodule

// ---- sim/tb_rrx_exec.sv ----
`timescale 1ns/1ns
module tb_rrx_exec
  import rrx_pkg::*;
;
  // ==========
  // signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, d, ec;
  logic        instr_valid, instr_ready, flush, push_valid, carry;
  logic        global_irq_enable, reset_instr_flag, device_reset_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] instr;
  logic [15:0] rets[4];
  logic [7:0]  file_rdata, w_reg, ew, f, k;
  logic [14:0] pc, push_addr, epc;
  logic [14:0] stk[$];
  rrx_fwr_t    file_wr;
  int          n_mismatch, num_checks, cyc;
  rrx_exec u_rrx_exec (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr, .file_rdata, .instr_ready, .flush, .push_valid,
    .push_addr, .pc, .w_reg, .carry, .global_irq_enable, .reset_instr_flag,
    .device_reset_req, .file_wr
  );
  // 50 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========
  // tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // apb master, holds the request until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one instruction; operand scrambled once taken
  task exec(input logic [15:0] w, input logic [7:0] fv);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr <= w;
    file_rdata <= fv;
    do @(posedge pclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    file_rdata <= ~fv;
    #1;
  endtask
  task push(input logic [14:0] a);
    @(posedge pclk);
    push_valid <= 1'b1;
    push_addr <= a;
    @(posedge pclk);
    push_valid <= 1'b0;
    stk.push_back(a);
  endtask
  // {new carry, result} of a left rotate
  function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
    return {v, c};
  endfunction
  // hang guard, run needs well under 1000 cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  // ==========
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, instr_valid, push_valid} = '0;
    {paddr, pwdata, instr, file_rdata, push_addr} = '0;
    void'($urandom(32'hbeca));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("flag", 1, reset_instr_flag);
    // reset values, unmapped word last
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(4 * i), 0, rd, er);
      chk("rd", i < 2, rd);
      chk("err", i == 5, er);
    end
    {epc, ec, ew} = '0;
    repeat (24)
    begin
      f = 8'($urandom);
      k = 8'($urandom);
      d = 1'($urandom);
      exec({6'h0d, d, 1'b0, k}, f);
      {ec, f} = rot(f, ec);
      epc++;
      if (!d)
        ew = f;
      chk("we", d, file_wr.we);
      if (d)
        chk("fdat", {k, f}, file_wr[15:0]);
      chk("w", ew, w_reg);
      chk("c", ec, carry);
      chk("pc", epc, pc);
    end
    // disabled core ignores the word
    apb(1'b1, ADDR_CTRL, 0, rd, er);
    exec(16'h34aa, 8'hff);
    chk("pc", epc, pc);
    apb(1'b1, ADDR_CTRL, 1, rd, er);
    // enable write must land before the return sets it again
    apb(1'b1, ADDR_IRQ, 32'h0000_0080, rd, er);
    apb(1'b0, ADDR_IRQ, 0, rd, er);
    chk("irq", 32'h0000_0080, rd);
    apb(1'b1, ADDR_IRQ, 0, rd, er);
    apb(1'b0, ADDR_IRQ, 0, rd, er);
    chk("irq", 32'h0000_0000, rd);
    for (int i = 0; i < 4; i++)
      push(15'($urandom));
    apb(1'b0, ADDR_STAT, 0, rd, er);
    chk("stat", 32'h0004_0000 | 32'(epc), rd);
    rets = '{OP_RETURN, OP_RETURN | 16'h0001, 16'h0c00, 16'h0010};
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 2) ? 8'($urandom) : 8'h00;
      exec(rets[i] | {8'h00, k}, 8'h00);
      epc = stk.pop_back();
      if (i == 2)
        ew = k;
      chk("pc", epc, pc);
      chk("w", ew, w_reg);
      chk("c", ec, carry);
      chk("rdy", 0, instr_ready);
      chk("flush", 1, flush);
      chk("irq_en", i == 3, global_irq_enable);
    end
    chk("irq_en", 1, global_irq_enable);
    apb(1'b0, ADDR_STAT, 0, rd, er);
    chk("stat", 32'(epc), rd);
    apb(1'b0, ADDR_IRQ, 0, rd, er);
    chk("irq", 32'h0000_0080, rd);
    exec(OP_RESET, 8'h00);
    chk("req", 1, device_reset_req);
    chk("flag", 0, reset_instr_flag);
    chk("pc", 0, pc);
    apb(1'b0, ADDR_PWR, 0, rd, er);
    chk("pwr", 0, rd);
    // requested reset applied by the bench
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("flag", 1, reset_instr_flag);
    chk("irq_en", 0, global_irq_enable);
    results();
  end
endmodule
bind rrx_exec rrx_exec_monitor u_rrx_exec_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .instr_valid,
  .instr, .file_rdata, .instr_ready, .flush, .pc, .w_reg, .carry, .global_irq_enable,
  .reset_instr_flag, .device_reset_req, .file_wr
);
